// file: rtl/rx_err_cfg.svh
// constants for the receive frame error reporting block
`ifndef RX_ERR_CFG_SVH
`define RX_ERR_CFG_SVH

// register indices; byte address is four times the index
`define IDX_MAX_FRAME      14'h0506
`define IDX_PLEN_CHECK     14'h050a
`define IDX_CTRL           14'h0510
`define IDX_IRQ_STATUS     14'h0511
`define IDX_IRQ_ENABLE     14'h0512
`define IDX_IRQ_CLEAR      14'h0513
`define IDX_LAST_FRAME     14'h0514

// reset values
`define RST_MAX_FRAME      32'h0000_05ee
`define RST_PLEN_CHECK     32'h0000_0000
`define RST_CTRL           32'h0000_0001
`define RST_ZERO           32'h0000_0000

// flag bit positions
`define FLAG_MALFORMED     0
`define FLAG_CRC           1
`define FLAG_UNDERSIZE     2
`define FLAG_OVERSIZE      3
`define FLAG_PLEN          4
`define FLAG_RESERVED      5

// size limits in bytes
`define RUNT_MIN_BYTES     16'h0009
`define RUNT_MAX_BYTES     16'h003f
`define LEN_TYPE_LIMIT     16'h0600
`define HDR_FCS_BYTES      16'h0012
`define MIN_PAYLOAD_BYTES  16'h002e

// control bits
`define CTRL_ALIGN_BIT     0
`define PLEN_EN_BIT        0

`endif

// file: rtl/rx_err_pkg.sv
// types shared by the receive frame error reporting block
package rx_err_pkg;

  // one beat of the receive stream as seen by the error logic
  typedef struct packed {
    logic        valid;     // beat carries frame bytes
    logic        sop;       // first beat of a frame
    logic        eop;       // last beat of a frame
    logic [6:0]  bytes;     // valid bytes in this beat
    logic        bad_ctrl;  // non-terminate control character seen
    logic        crc_fail;  // checksum result, meaningful with eop
    logic        len_vld;   // length field captured this beat
    logic [15:0] len;       // length/type field value
  } rx_beat_t;

  // per-frame report to the client
  typedef struct packed {
    logic       eop;        // end-of-packet cycle of the report
    logic [5:0] flags;      // frame error flags, zero outside eop
    logic       fcs_err;    // checksum error
    logic       fcs_valid;  // fcs_err holds a valid value
  } rx_report_t;

endpackage : rx_err_pkg

// file: rtl/rx_frame_error_report.sv
// receive frame classification and error flag reporting with apb registers
//
// Contract
// - Error flag vector is meaningful only in end-of-packet cycles.
// - Bit 0 set when a non-terminate control character appears mid-packet.
// - Bit 1 set when the frame checksum check fails.
// - With alignment on, bit 1 and checksum error output are identical.
// - Bit 2 set for frames of nine to 63 bytes inclusive.
// - Units of eight bytes or fewer are not frames, never undersized.
// - Bit 3 set when frame size exceeds programmed maximum frame size.
// - Bit 4 set when payload mismatches a length field below 1536.
// - Bit 4 reported only while payload length check bit 0 is one.
// - Checksum error output asserted for frames with a bad checksum.
// - By default checksum error appears in the end-of-packet cycle.
// - With alignment off checksum error may lag end-of-packet.
// - Runt frames always raise the checksum error condition.
// - Eight bytes or fewer is a decoding error, not a runt.
// - Checksum-valid qualifier high whenever checksum error output is valid.
`timescale 1ns/1ps
`default_nettype none
`include "rx_err_cfg.svh"

module rx_frame_error_report #(
  parameter int SIZE_W = 16                          // frame byte counter width
) (
  input  wire logic                   ref_clk,       // rx mac clock, 10 MHz
  input  wire logic                   rstn,          // synchronous reset, low active
  input  wire logic                   ce,            // clock enable, low freezes state
  input  wire rx_err_pkg::rx_beat_t   beat,          // receive stream observation
  output var  rx_err_pkg::rx_report_t report,        // per-frame error report
  output logic                        irq,           // level interrupt
  input  wire logic                   psel,          // apb select
  input  wire logic                   penable,       // apb enable
  input  wire logic                   pwrite,        // apb direction
  input  wire logic [15:0]            paddr,         // apb byte address
  input  wire logic [31:0]            pwdata,        // apb write data
  output logic [31:0]                 prdata,        // apb read data
  output logic                        pready,        // apb ready
  output logic                        pslverr        // apb error, unmapped address
);

  // byte address of a register index
  function automatic logic reg_hit(input logic [15:0] addr, input logic [13:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction : reg_hit

  // saturating add keeps a runaway frame from wrapping into a small size
  function automatic logic [SIZE_W-1:0] sat_add(input logic [SIZE_W-1:0] a, input logic [6:0] b);
    logic [SIZE_W:0] s;
    s = {1'b0, a} + {{(SIZE_W-6){1'b0}}, b};
    sat_add = s[SIZE_W] ? {SIZE_W{1'b1}} : s[SIZE_W-1:0];
  endfunction : sat_add

  // ---------------------------------------------------------------- registers
  logic [31:0]      max_frame_r;
  logic [31:0]      max_frame_nxt;
  logic [31:0]      plen_ctrl_r;
  logic [31:0]      plen_ctrl_nxt;
  logic [31:0]      ctrl_r;
  logic [31:0]      ctrl_nxt;
  logic [4:0]       irq_sts_r;
  logic [4:0]       irq_sts_nxt;
  logic [4:0]       irq_en_r;
  logic [4:0]       irq_en_nxt;
  logic [5:0]       last_flags_r;
  logic [5:0]       last_flags_nxt;
  logic [SIZE_W-1:0] last_size_r;
  logic [SIZE_W-1:0] last_size_nxt;

  // ---------------------------------------------------------------- apb decode
  logic        acc_w;
  logic        done_w;
  logic        wr_w;
  logic        hit_max_w;
  logic        hit_plen_w;
  logic        hit_ctrl_w;
  logic        hit_sts_w;
  logic        hit_en_w;
  logic        hit_clr_w;
  logic        hit_last_w;
  logic        mapped_w;
  logic [31:0] rd_mux_w;

  assign acc_w      = psel & penable;
  assign done_w     = acc_w & pready;
  assign wr_w       = done_w & pwrite & mapped_w;
  assign hit_max_w  = reg_hit(paddr, `IDX_MAX_FRAME);
  assign hit_plen_w = reg_hit(paddr, `IDX_PLEN_CHECK);
  assign hit_ctrl_w = reg_hit(paddr, `IDX_CTRL);
  assign hit_sts_w  = reg_hit(paddr, `IDX_IRQ_STATUS);
  assign hit_en_w   = reg_hit(paddr, `IDX_IRQ_ENABLE);
  assign hit_clr_w  = reg_hit(paddr, `IDX_IRQ_CLEAR);
  assign hit_last_w = reg_hit(paddr, `IDX_LAST_FRAME);
  assign mapped_w   = hit_max_w | hit_plen_w | hit_ctrl_w | hit_sts_w |
                      hit_en_w | hit_clr_w | hit_last_w;

  logic [31:0] rd_sts_w;
  logic [31:0] rd_en_w;
  logic [31:0] rd_last_w;

  // narrow registers are zero-extended to the bus word
  assign rd_sts_w  = {27'h000_0000, irq_sts_r};
  assign rd_en_w   = {27'h000_0000, irq_en_r};
  assign rd_last_w = {{(26-SIZE_W){1'b0}}, last_size_r, last_flags_r};

  // clear register reads zero; status and last-frame are read only
  assign rd_mux_w = hit_max_w  ? max_frame_r :
                    hit_plen_w ? plen_ctrl_r :
                    hit_ctrl_w ? ctrl_r :
                    hit_sts_w  ? rd_sts_w :
                    hit_en_w   ? rd_en_w :
                    hit_last_w ? rd_last_w :
                    `RST_ZERO;

  assign max_frame_nxt = (wr_w & hit_max_w)  ? pwdata : max_frame_r;
  assign plen_ctrl_nxt = (wr_w & hit_plen_w) ? pwdata : plen_ctrl_r;
  assign ctrl_nxt      = (wr_w & hit_ctrl_w) ? pwdata : ctrl_r;
  assign irq_en_nxt    = (wr_w & hit_en_w)   ? pwdata[4:0] : irq_en_r;

  logic        rd_take_w;
  logic        pready_nxt;
  logic        pslverr_nxt;
  logic [31:0] prdata_nxt;

  // one wait state: ready rises in the second access cycle, then drops
  assign rd_take_w   = acc_w & ~pready & ~pwrite;
  assign pready_nxt  = acc_w & ~pready;
  assign pslverr_nxt = acc_w & ~pready & ~mapped_w;
  // read data holds between reads, so a slow sampler still finds it
  assign prdata_nxt  = rd_take_w ? rd_mux_w : prdata;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= pready_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      prdata <= `RST_ZERO;
    end else if (ce) begin
      prdata <= prdata_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pslverr <= 1'b0;
    end else if (ce) begin
      pslverr <= pslverr_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      max_frame_r <= `RST_MAX_FRAME;
    end else if (ce) begin
      max_frame_r <= max_frame_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      plen_ctrl_r <= `RST_PLEN_CHECK;
    end else if (ce) begin
      plen_ctrl_r <= plen_ctrl_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl_r <= `RST_CTRL;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq_en_r <= 5'h00;
    end else if (ce) begin
      irq_en_r <= irq_en_nxt;
    end
  end

  // ---------------------------------------------------------------- frame tracking
  logic [SIZE_W-1:0] size_acc_r;
  logic [SIZE_W-1:0] size_acc_nxt;
  logic              bad_ctrl_r;
  logic              bad_ctrl_nxt;
  logic [15:0]       len_r;
  logic [15:0]       len_nxt;
  logic              len_seen_r;
  logic              len_seen_nxt;

  logic [SIZE_W-1:0] base_w;
  logic [SIZE_W-1:0] size_w;
  logic              end_w;
  logic              bad_any_w;
  logic [15:0]       len_cur_w;
  logic              len_ok_w;

  // a sop beat restarts the count even if the previous frame lost its eop
  assign base_w    = beat.sop ? {SIZE_W{1'b0}} : size_acc_r;
  assign size_w    = sat_add(base_w, beat.bytes);
  assign end_w     = beat.valid & beat.eop;
  assign bad_any_w = (beat.sop ? 1'b0 : bad_ctrl_r) | beat.bad_ctrl;
  assign len_cur_w = beat.len_vld ? beat.len : len_r;
  assign len_ok_w  = beat.len_vld | (~beat.sop & len_seen_r);

  assign size_acc_nxt = !beat.valid ? size_acc_r :
                        beat.eop    ? {SIZE_W{1'b0}} : size_w;
  assign bad_ctrl_nxt = !beat.valid ? bad_ctrl_r :
                        beat.eop    ? 1'b0 : bad_any_w;
  assign len_nxt      = (beat.valid & beat.len_vld) ? beat.len : len_r;
  assign len_seen_nxt = !beat.valid ? len_seen_r :
                        beat.eop    ? 1'b0 : len_ok_w;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      size_acc_r <= {SIZE_W{1'b0}};
    end else if (ce) begin
      size_acc_r <= size_acc_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bad_ctrl_r <= 1'b0;
    end else if (ce) begin
      bad_ctrl_r <= bad_ctrl_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      len_r <= 16'h0000;
    end else if (ce) begin
      len_r <= len_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      len_seen_r <= 1'b0;
    end else if (ce) begin
      len_seen_r <= len_seen_nxt;
    end
  end

  // ---------------------------------------------------------------- classification
  logic              tiny_w;
  logic              runt_w;
  logic              over_w;
  logic              crc_bad_w;
  logic [15:0]       payload_w;
  logic [15:0]       expect_w;
  logic              plen_w;
  logic              align_w;
  logic [5:0]        flags_w;

  // eight bytes or fewer is a decoding error, never a runt
  assign tiny_w    = (size_w < `RUNT_MIN_BYTES);
  assign runt_w    = ~tiny_w & (size_w <= `RUNT_MAX_BYTES);
  assign over_w    = ({{(32-SIZE_W){1'b0}}, size_w} > max_frame_r);
  // runts force the checksum error whatever the check said
  assign crc_bad_w = beat.crc_fail | runt_w;
  assign payload_w = (size_w > `HDR_FCS_BYTES) ? 16'(size_w - `HDR_FCS_BYTES) : 16'h0000;
  // short payloads are padded, so compare against the padded minimum
  assign expect_w  = (len_cur_w < `MIN_PAYLOAD_BYTES) ? `MIN_PAYLOAD_BYTES : len_cur_w;
  assign plen_w    = plen_ctrl_r[`PLEN_EN_BIT] & len_ok_w &
                     (len_cur_w < `LEN_TYPE_LIMIT) & (payload_w != expect_w);
  assign align_w   = ctrl_r[`CTRL_ALIGN_BIT];

  always_comb begin
    flags_w                  = 6'h00;
    flags_w[`FLAG_MALFORMED] = bad_any_w | tiny_w;
    flags_w[`FLAG_CRC]       = crc_bad_w;
    flags_w[`FLAG_UNDERSIZE] = runt_w;
    flags_w[`FLAG_OVERSIZE]  = over_w;
    flags_w[`FLAG_PLEN]      = plen_w;
    flags_w[`FLAG_RESERVED]  = 1'b0;
  end

  // ---------------------------------------------------------------- report outputs
  logic       fcs_pend_r;
  logic       fcs_pend_nxt;
  logic       fcs_pend_err_r;
  logic       fcs_pend_err_nxt;
  rx_err_pkg::rx_report_t report_nxt;

  // with alignment off the checksum verdict trails the report by one cycle
  assign fcs_pend_nxt     = end_w & ~align_w;
  assign fcs_pend_err_nxt = end_w & ~align_w & crc_bad_w;

  always_comb begin
    report_nxt           = '0;
    report_nxt.eop       = end_w;
    report_nxt.flags     = end_w ? flags_w : 6'h00;
    if (align_w) begin
      report_nxt.fcs_valid = end_w;
      report_nxt.fcs_err   = end_w & crc_bad_w;
    end else begin
      report_nxt.fcs_valid = fcs_pend_r;
      report_nxt.fcs_err   = fcs_pend_err_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      report <= '0;
    end else if (ce) begin
      report <= report_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      fcs_pend_r <= 1'b0;
    end else if (ce) begin
      fcs_pend_r <= fcs_pend_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      fcs_pend_err_r <= 1'b0;
    end else if (ce) begin
      fcs_pend_err_r <= fcs_pend_err_nxt;
    end
  end

  // ---------------------------------------------------------------- last frame, interrupts
  logic [4:0] evt_w;
  logic [4:0] clr_w;
  logic       irq_nxt;

  assign evt_w          = end_w ? flags_w[4:0] : 5'h00;
  assign clr_w          = (wr_w & hit_clr_w) ? pwdata[4:0] : 5'h00;
  // an event in the clearing cycle survives the clear
  assign irq_sts_nxt    = (irq_sts_r & ~clr_w) | evt_w;
  assign last_flags_nxt = end_w ? flags_w : last_flags_r;
  assign last_size_nxt  = end_w ? size_w : last_size_r;
  // built from next state so the interrupt rises with the report
  assign irq_nxt        = |(irq_sts_nxt & irq_en_nxt);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq_sts_r <= 5'h00;
    end else if (ce) begin
      irq_sts_r <= irq_sts_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      last_flags_r <= 6'h00;
    end else if (ce) begin
      last_flags_r <= last_flags_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      last_size_r <= {SIZE_W{1'b0}};
    end else if (ce) begin
      last_size_r <= last_size_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= irq_nxt;
    end
  end

endmodule : rx_frame_error_report

`default_nettype wire

// file: testbench/rx_client_model.sv
// client receive model consuming the per-frame error report
`timescale 1ns/1ps
`default_nettype none
module rx_client_model (
  input  wire logic                   ref_clk,   // rx mac clock
  input  wire logic                   rstn,      // sync reset, low active
  input  wire rx_err_pkg::rx_report_t report,    // report from the block
  output var  int                     frame_cnt, // frames seen
  output var  int                     fcs_cnt    // checksum errors seen
);
  // flags mean nothing outside eop, so only eop cycles are counted
  always_ff @(posedge ref_clk)
    if (!rstn) frame_cnt <= 0;
    else if (report.eop) frame_cnt <= frame_cnt + 1;
  // the verdict may trail eop, so it is taken on its own qualifier
  always_ff @(posedge ref_clk)
    if (!rstn) fcs_cnt <= 0;
    else if (report.fcs_valid && report.fcs_err) fcs_cnt <= fcs_cnt + 1;
endmodule : rx_client_model
`default_nettype wire

// file: testbench/rx_frame_error_report_sva.sv
// assertion checker for the receive frame error report block
`timescale 1ns/1ps
`default_nettype none
module rx_err_chk (
  input wire logic                   ref_clk, // rx mac clock
  input wire logic                   rstn,    // sync reset, low active
  input wire logic                   ce,      // clock enable
  input wire rx_err_pkg::rx_beat_t   beat,    // stream in
  input wire rx_err_pkg::rx_report_t report,  // report out
  input wire logic                   psel,    // apb select
  input wire logic                   penable, // apb enable
  input wire logic                   pready,  // apb ready
  input wire logic                   pslverr  // apb error
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [15:0] sz_r;
  logic [15:0] sz_nxt;
  wire         end_w = beat.valid && beat.eop && ce;
  // running size; sop restarts it so a lost eop cannot pollute the next frame
  assign sz_nxt = (beat.sop ? 16'h0000 : sz_r) + 16'(beat.bytes);
  always_ff @(posedge ref_clk)
    if (!rstn) sz_r <= 16'h0000;
    else if (beat.valid && ce) sz_r <= sz_nxt;

  a_flags_eop: assert property (report.flags != 6'h00 |-> report.eop) else $error("flags outside eop");
  a_resv_zero: assert property (!report.flags[5]) else $error("reserved flag set");
  a_eop_follow: assert property (end_w |=> report.eop) else $error("report eop missing");
  a_eop_cause: assert property (report.eop |-> $past(end_w)) else $error("report eop without frame");
  a_crc_flag: assert property (end_w && beat.crc_fail |=> report.flags[1]) else $error("crc flag missing");
  a_fcs_qual: assert property (report.fcs_err |-> report.fcs_valid) else $error("fcs error unqualified");
  a_crc_match: assert property (report.eop && report.fcs_valid && !$past(report.eop)
    |-> report.fcs_err == report.flags[1]) else $error("crc flag and fcs differ");
  a_runt_fcs: assert property (end_w && sz_nxt >= 16'h0009 && sz_nxt <= 16'h003f
    |=> report.flags[2] ##[0:1] report.fcs_err) else $error("runt not reported");
  a_tiny_frame: assert property (end_w && sz_nxt <= 16'h0008
    |=> !report.flags[2] && report.flags[0]) else $error("tiny unit misreported");
  a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready) else $error("apb wait state wrong");
  a_err_ready: assert property (pslverr |-> pready) else $error("slave error without ready");

  c_runt: cover property (report.flags[2]);
  c_over: cover property (report.flags[3]);
  c_plen: cover property (report.flags[4]);
  c_lag: cover property (report.fcs_valid && !report.eop);
endmodule : rx_err_chk

bind rx_frame_error_report rx_err_chk u_chk (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .beat(beat),
  .report(report), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// file: testbench/rx_frame_error_report_tb.sv
// self-checking bench for the receive frame error report block
`timescale 1ns/1ps
`default_nettype none
`include "rx_err_cfg.svh"
module rx_frame_error_report_tb;
  logic                   ref_clk, rstn, ce, psel, penable, pwrite, irq, pready, pslverr, er, align, plen_en;
  logic                   stall;
  logic [15:0]            paddr, max_sz;
  logic [31:0]            pwdata, prdata, rd, seed;
  rx_err_pkg::rx_beat_t   beat;
  rx_err_pkg::rx_report_t report;
  int                     error_cnt, tests_run, frames, fcs_exp, frame_cnt, fcs_cnt, n;
  int                     corners[6] = '{8, 9, 63, 64, 1518, 1519};

  rx_frame_error_report DUT (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .beat(beat), .report(report),
    .irq(irq), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  rx_client_model client (.ref_clk(ref_clk), .rstn(rstn), .report(report), .frame_cnt(frame_cnt),
    .fcs_cnt(fcs_cnt));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [5:0] exp_flags(input int sz, input logic bad, input logic crc, input logic [15:0] len);
    logic [5:0] f;
    int         pl;
    f = '0;
    pl = (len < 16'h002e) ? 46 : int'(len);
    f[0] = bad || sz <= 8;
    f[1] = crc || (sz >= 9 && sz <= 63);
    f[2] = sz >= 9 && sz <= 63;
    f[3] = sz > max_sz;
    f[4] = plen_en && len < 16'h0600 && (sz - 18) != pl;
    return f;
  endfunction : exp_flags

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no answer time is assumed; only the watchdog ends a wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic frame(input int sz, input logic bad, input logic crc, input logic [15:0] len);
    int         left;
    logic [5:0] f;
    left = sz;
    f = exp_flags(sz, bad, crc, len);
    frames++;
    fcs_exp += f[1];
    while (left > 0) begin
      @(posedge ref_clk);
      beat <= '{valid: 1'b1, sop: left == sz, eop: left <= 64, bytes: 7'(left > 64 ? 64 : left),
                bad_ctrl: bad && left <= 64, crc_fail: crc, len_vld: left == sz, len: len};
      left -= 64;
      // a frozen cycle must neither take the held beat nor lose it
      if (stall) begin
        ce <= 1'b0;
        @(posedge ref_clk);
        ce <= 1'b1;
      end
    end
    @(posedge ref_clk);
    beat <= '0;
    #1;
    check(report.eop, 1'b1, "eop");
    check(report.flags, f, "flags");
    check(report.fcs_valid, align, "fcs in eop cycle");
    if (!align) begin
      @(posedge ref_clk);
      #1;
      check(report.fcs_valid, 1'b1, "late fcs");
    end
    check(report.fcs_err, f[1], "fcs error");
  endtask : frame

  task automatic test_done;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    $display("mismatch t=%0t watchdog expired", $time);
    test_done();
  end

  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, beat} = '0;
    {error_cnt, tests_run, frames, fcs_exp} = '0;
    ce = 1'b1;
    stall = 1'b0;
    seed = 32'h0000_0014;
    align = 1'b1;
    plen_en = 1'b0;
    max_sz = 16'h05ee;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    apb(1'b0, `IDX_MAX_FRAME, 32'h0000_0000);
    check(rd, `RST_MAX_FRAME, "max frame reset");
    apb(1'b0, `IDX_PLEN_CHECK, 32'h0000_0000);
    check(rd, `RST_PLEN_CHECK, "plen reset");
    apb(1'b0, `IDX_CTRL, 32'h0000_0000);
    check(rd, `RST_CTRL, "ctrl reset");
    apb(1'b0, 14'h0100, 32'h0000_0000);
    check(er, 1'b1, "unmapped");
    foreach (corners[i]) frame(corners[i], 1'b0, 1'b0, 16'h0800);
    frame(200, 1'b0, 1'b0, 16'h0010);
    apb(1'b0, `IDX_LAST_FRAME, 32'h0000_0000);
    check(rd, {10'h000, 16'h00c8, 6'h00}, "last frame");
    check(irq, 1'b0, "masked irq");
    apb(1'b1, `IDX_IRQ_CLEAR, 32'h0000_001f);
    apb(1'b1, `IDX_IRQ_ENABLE, 32'h0000_0002);
    repeat (2) @(posedge ref_clk);
    #1;
    check(irq, 1'b0, "cleared irq");
    frame(100, 1'b0, 1'b1, 16'h0800);
    check(irq, 1'b1, "crc irq");
    apb(1'b0, `IDX_IRQ_STATUS, 32'h0000_0000);
    check(rd[1], 1'b1, "status crc");
    apb(1'b1, `IDX_IRQ_CLEAR, 32'h0000_0002);
    repeat (2) @(posedge ref_clk);
    #1;
    check(irq, 1'b0, "irq after clear");
    max_sz = 16'd1000;
    apb(1'b1, `IDX_MAX_FRAME, 32'(max_sz));
    plen_en = 1'b1;
    apb(1'b1, `IDX_PLEN_CHECK, 32'h0000_0001);
    for (int i = 0; i < 40; i++) begin
      if (i == 20) begin
        align = 1'b0;
        apb(1'b1, `IDX_CTRL, 32'h0000_0000);
      end
      stall = xs() % 4 == 0;
      n = 1 + int'(xs() % 1100);
      frame(n, xs() % 8 == 0, xs() % 4 == 0, xs() % 2 ? 16'(n - 18) : 16'(xs() % 1600));
    end
    repeat (2) @(posedge ref_clk);
    check(frame_cnt, frames, "client frames");
    check(fcs_cnt, fcs_exp, "client fcs errors");
    test_done();
  end
endmodule : rx_frame_error_report_tb
`default_nettype wire
